// ---- otfs_pkg.sv ----
// Constants, register map and state types for overtravel and forced-stop control
// Behaviour
// - Forward limit ON permits forward run; OFF prohibits it and flags forward overtravel.
// - Reverse limit ON permits reverse run; OFF prohibits it and flags reverse overtravel.
// - Forward limit enable at 1 ignores the input; default 0; adopted at restart.
// - Reverse limit enable at 1 ignores the input; default 0; adopted at restart.
// - Overtravel is off when no terminal carries function code 1 or 2.
// - Forced-stop input ON means normal running; OFF forces the motor to stop.
// - Forced stop offers dynamic-brake, coasting and controlled deceleration stops.
// - With code 0xA allocated, only the forced-stop input stops; controlword quick stop is off.
// - Method 0 uses the profile quick-stop option and deceleration objects; set at reboot.
// - Method 1 uses the own forced-stop mode and deceleration time settings.
// - Mode accepts 0 to 6, default 0; 3 and 4 act as option 0; immediate.
// - Deceleration time 0 to 65535 ms per 1000 rpm, default 1000, immediate.
// - Enable arriving while forced-stop input is OFF keeps forced stop, even after ON.
// - Overtravel method 0..3 selects brake and after-stop combination; set at restart.
// - Reverse braking zeroes speed reference and limits torque, 0 to 350 percent, default 300.
package otfs_pkg;

  localparam int NTERM = 5;

  // Register byte addresses
  localparam logic [7:0] ADR_CFG_RST  = 8'h00;
  localparam logic [7:0] ADR_ALLOC_A  = 8'h04;
  localparam logic [7:0] ADR_ALLOC_B  = 8'h08;
  localparam logic [7:0] ADR_FS_MODE  = 8'h0C;
  localparam logic [7:0] ADR_FS_DECEL = 8'h10;
  localparam logic [7:0] ADR_RB_TORQ  = 8'h14;
  localparam logic [7:0] ADR_STATUS   = 8'h18;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADR_CTRL     = 8'h24;

  // Restart-latched configuration field positions and the restart control bit
  localparam int CFG_FWD_DIS = 0;
  localparam int CFG_REV_DIS = 1;
  localparam int CFG_FS_METH = 2;
  localparam int CFG_OT_METH = 4;
  localparam int CTRL_RESTART = 0;

  // Status and interrupt bit positions
  localparam int EV_FWD_OT  = 0;
  localparam int EV_REV_OT  = 1;
  localparam int EV_FSTOP   = 2;
  localparam int EV_HELD    = 3;
  localparam int NEV        = 4;

  // Reset values and range limits
  localparam logic [5:0]  CFG_RST_VAL   = 6'h00;
  localparam logic [15:0] ALLOC_A_RST   = 16'h0021;
  localparam logic [3:0]  ALLOC_B_RST   = 4'h0;
  localparam logic [2:0]  FS_MODE_RST   = 3'h0;
  localparam logic [2:0]  FS_MODE_MAX   = 3'h6;
  localparam logic [15:0] FS_DECEL_RST  = 16'h03E8;
  localparam logic [8:0]  RB_TORQ_RST   = 9'h12C;
  localparam logic [8:0]  RB_TORQ_MAX   = 9'h15E;

  // Input function codes
  localparam logic [3:0] FN_FWD_LIMIT = 4'h1;
  localparam logic [3:0] FN_REV_LIMIT = 4'h2;
  localparam logic [3:0] FN_FSTOP     = 4'hA;

  // Stop actions and after-stop states
  localparam logic [1:0] STOP_DB    = 2'h0;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] STOP_DECEL = 2'h2;
  localparam logic [1:0] STOP_RBRK  = 2'h3;
  localparam logic [1:0] AFT_COAST  = 2'h0;
  localparam logic [1:0] AFT_DB     = 2'h1;
  localparam logic [1:0] AFT_ZCLAMP = 2'h2;

  // Forced-stop mode values that fold to option 0, and the quick-stop option codes
  localparam logic [2:0] FS_FOLD_A = 3'h3;
  localparam logic [2:0] FS_FOLD_B = 3'h4;
  localparam logic [2:0] QS_OPT_DB = 3'h0;
  localparam logic [2:0] QS_OPT_COAST = 3'h1;

  typedef enum logic [1:0] {
    OTFS_READY = 2'b00,
    OTFS_RUN   = 2'b01,
    OTFS_FSTOP = 2'b10
  } otfs_state_t;

endpackage

// ---- otfs_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module otfs_sync #(
  parameter int W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second; reset to OFF keeps the drive stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule
`default_nettype wire

// ---- otfs_top.sv ----
// Overtravel limit and forced-stop control with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
module otfs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  // Input terminals, active high means ON
  input  wire logic [4:0]  term_i,
  // Drive-profile command side
  input  wire logic        cw_enable_i,
  input  wire logic        cw_quick_stop_i,
  input  wire logic [2:0]  qs_option_i,
  input  wire logic        cmd_fwd_i,
  input  wire logic        cmd_rev_i,
  // Motion decisions
  output logic             fwd_move_o,
  output logic             rev_move_o,
  output logic             fwd_ot_o,
  output logic             rev_ot_o,
  output logic             ot_stop_o,
  output logic [1:0]       stop_action_o,
  output logic [1:0]       after_stop_o,
  output logic             speed_ref_zero_o,
  output logic [8:0]       torque_limit_o,
  output logic             torque_limit_act_o,
  // Forced-stop and state outputs
  output logic             ready_o,
  output logic             servo_on_o,
  output logic             fstop_o,
  output logic             use_profile_o,
  output logic [2:0]       stop_option_o,
  output logic [15:0]      decel_time_o,
  output logic             quick_stop_o
);

  // Finds the terminal carrying a function code: {allocated, level}
  function automatic logic [1:0] find_sig(input logic [19:0] map,
                                          input logic [4:0]  lvl,
                                          input logic [3:0]  code);
    logic f;
    logic v;
    f = 1'b0;
    v = 1'b0;
    for (int i = 0; i < otfs_pkg::NTERM; i++) begin
      if (map[i*4 +: 4] == code && !f) begin
        f = 1'b1;
        v = lvl[i];
      end
    end
    return {f, v};
  endfunction

  logic [4:0]  term_sync;
  logic [5:0]  cfg_pend_ff;
  logic [5:0]  cfg_act_ff;
  logic [15:0] alloc_a_ff;
  logic [3:0]  alloc_b_ff;
  logic [2:0]  fs_mode_ff;
  logic [15:0] fs_decel_ff;
  logic [8:0]  rb_torq_ff;
  logic [otfs_pkg::NEV-1:0] irq_stat_ff;
  logic [otfs_pkg::NEV-1:0] irq_mask_ff;
  logic [otfs_pkg::NEV-1:0] ev;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        fwd_ot_ff;
  logic        rev_ot_ff;
  logic        en_ff;
  otfs_pkg::otfs_state_t state_ff;
  otfs_pkg::otfs_state_t nxt_state;

  // Limit and stop terminals settle through two flops first
  otfs_sync #(
    .W (otfs_pkg::NTERM)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (term_i),
    .sync_o  (term_sync)
  );

  // Bus decode
  logic        req;
  logic        wr;
  logic        rd;
  logic [19:0] alloc_map;
  assign req       = cyc_i & stb_i & ~ack_ff;
  assign wr        = req & we_i & sel_i[0];
  assign rd        = req & ~we_i;
  assign alloc_map = {alloc_b_ff, alloc_a_ff};

  // Signal lookup on the allocation map
  logic [1:0] fwd_sig;
  logic [1:0] rev_sig;
  logic [1:0] fs_sig;
  assign fwd_sig = find_sig(alloc_map, term_sync, otfs_pkg::FN_FWD_LIMIT);
  assign rev_sig = find_sig(alloc_map, term_sync, otfs_pkg::FN_REV_LIMIT);
  assign fs_sig  = find_sig(alloc_map, term_sync, otfs_pkg::FN_FSTOP);

  // Direction permission; an unallocated limit cannot block motion
  logic fwd_ok;
  logic rev_ok;
  logic fs_in_ok;
  assign fwd_ok = cfg_act_ff[otfs_pkg::CFG_FWD_DIS] | ~fwd_sig[1] | fwd_sig[0];
  assign rev_ok = cfg_act_ff[otfs_pkg::CFG_REV_DIS] | ~rev_sig[1] | rev_sig[0];
  // Without an allocated stop terminal the stop input reads as ON
  assign fs_in_ok = ~fs_sig[1] | fs_sig[0];

  // Configuration writes; low byte lane required, and alloc_a_ff bits 15:8 also need lane 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_pend_ff <= otfs_pkg::CFG_RST_VAL;
      alloc_a_ff  <= otfs_pkg::ALLOC_A_RST;
      alloc_b_ff  <= otfs_pkg::ALLOC_B_RST;
    end else if (wr) begin
      case (adr_i)
        otfs_pkg::ADR_CFG_RST: cfg_pend_ff <= dat_i[5:0];
        otfs_pkg::ADR_ALLOC_A: begin
          alloc_a_ff[7:0] <= dat_i[7:0];
          if (sel_i[1]) begin
            alloc_a_ff[15:8] <= dat_i[15:8];
          end
        end
        otfs_pkg::ADR_ALLOC_B: alloc_b_ff <= dat_i[3:0];
        default: ;
      endcase
    end
  end

  // Pending settings become active only on restart, as a reboot would
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_act_ff <= otfs_pkg::CFG_RST_VAL;
    end else if (wr && adr_i == otfs_pkg::ADR_CTRL && dat_i[otfs_pkg::CTRL_RESTART]) begin
      cfg_act_ff <= cfg_pend_ff;
    end
  end

  // Immediate settings; out-of-range writes are dropped, old value kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_mode_ff  <= otfs_pkg::FS_MODE_RST;
      fs_decel_ff <= otfs_pkg::FS_DECEL_RST;
      rb_torq_ff  <= otfs_pkg::RB_TORQ_RST;
    end else if (wr) begin
      if (adr_i == otfs_pkg::ADR_FS_MODE && dat_i[2:0] <= otfs_pkg::FS_MODE_MAX) begin
        fs_mode_ff <= dat_i[2:0];
      end
      if (adr_i == otfs_pkg::ADR_FS_DECEL && sel_i[1]) begin
        fs_decel_ff <= dat_i[15:0];
      end
      if (adr_i == otfs_pkg::ADR_RB_TORQ && sel_i[1] &&
          dat_i[8:0] <= otfs_pkg::RB_TORQ_MAX) begin
        rb_torq_ff <= dat_i[8:0];
      end
    end
  end

  // Enable edge detect for the servo ON command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= 1'b0;
    end else begin
      en_ff <= cw_enable_i;
    end
  end

  // Drive state: forced stop is left only through disable, ready, enable
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      otfs_pkg::OTFS_READY: begin
        if (cw_enable_i && !fs_in_ok) begin
          nxt_state = otfs_pkg::OTFS_FSTOP;
        end else if (cw_enable_i) begin
          nxt_state = otfs_pkg::OTFS_RUN;
        end
      end
      otfs_pkg::OTFS_RUN: begin
        if (!fs_in_ok) begin
          nxt_state = otfs_pkg::OTFS_FSTOP;
        end else if (!cw_enable_i) begin
          nxt_state = otfs_pkg::OTFS_READY;
        end
      end
      otfs_pkg::OTFS_FSTOP: begin
        // Stop input coming back ON alone does not release the drive
        if (!cw_enable_i && fs_in_ok) begin
          nxt_state = otfs_pkg::OTFS_READY;
        end
      end
      default: nxt_state = otfs_pkg::OTFS_READY;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= otfs_pkg::OTFS_READY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Forced-stop option: modes 3 and 4 fold to option 0
  logic [2:0] own_opt;
  logic       meth_own;
  logic       qs_ok;
  assign own_opt = (fs_mode_ff == otfs_pkg::FS_FOLD_A || fs_mode_ff == otfs_pkg::FS_FOLD_B) ?
                   otfs_pkg::QS_OPT_DB : fs_mode_ff;
  assign meth_own = cfg_act_ff[otfs_pkg::CFG_FS_METH];
  // Controlword quick stop is withheld once the stop terminal exists
  assign qs_ok = ~fs_sig[1];

  // Forced-stop outputs
  logic [2:0] nxt_opt;
  logic [1:0] fs_action;
  always_comb begin
    nxt_opt = meth_own ? own_opt : qs_option_i;
    case (nxt_opt)
      otfs_pkg::QS_OPT_DB:    fs_action = otfs_pkg::STOP_DB;
      otfs_pkg::QS_OPT_COAST: fs_action = otfs_pkg::STOP_COAST;
      default:                fs_action = otfs_pkg::STOP_DECEL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o       <= 1'b1;
      servo_on_o    <= 1'b0;
      fstop_o       <= 1'b0;
      use_profile_o <= 1'b1;
      stop_option_o <= otfs_pkg::QS_OPT_DB;
      decel_time_o  <= otfs_pkg::FS_DECEL_RST;
      quick_stop_o  <= 1'b0;
    end else begin
      ready_o       <= nxt_state == otfs_pkg::OTFS_READY;
      servo_on_o    <= nxt_state == otfs_pkg::OTFS_RUN;
      fstop_o       <= nxt_state == otfs_pkg::OTFS_FSTOP;
      use_profile_o <= ~meth_own;
      stop_option_o <= nxt_opt;
      decel_time_o  <= fs_decel_ff;
      quick_stop_o  <= cw_quick_stop_i & qs_ok & (state_ff == otfs_pkg::OTFS_RUN);
    end
  end

  // Overtravel stop method table
  logic [1:0] ot_action;
  logic [1:0] ot_after;
  always_comb begin
    case (cfg_act_ff[otfs_pkg::CFG_OT_METH +: 2])
      2'h1: begin
        ot_action = otfs_pkg::STOP_DB;
        ot_after  = otfs_pkg::AFT_DB;
      end
      2'h2: begin
        ot_action = otfs_pkg::STOP_RBRK;
        ot_after  = otfs_pkg::AFT_ZCLAMP;
      end
      2'h3: begin
        ot_action = otfs_pkg::STOP_RBRK;
        ot_after  = otfs_pkg::AFT_COAST;
      end
      default: begin
        ot_action = otfs_pkg::STOP_DB;
        ot_after  = otfs_pkg::AFT_COAST;
      end
    endcase
  end

  // Motion gating; the free direction still runs to back out of a limit
  logic ot_hit;
  logic run;
  // Follows the next state so motion drops in the same cycle as fstop_o rises
  assign run    = nxt_state == otfs_pkg::OTFS_RUN;
  assign ot_hit = (cmd_fwd_i & ~fwd_ok) | (cmd_rev_i & ~rev_ok);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_move_o         <= 1'b0;
      rev_move_o         <= 1'b0;
      fwd_ot_ff          <= 1'b0;
      rev_ot_ff          <= 1'b0;
      ot_stop_o          <= 1'b0;
      stop_action_o      <= otfs_pkg::STOP_DB;
      after_stop_o       <= otfs_pkg::AFT_COAST;
      speed_ref_zero_o   <= 1'b0;
      torque_limit_o     <= otfs_pkg::RB_TORQ_RST;
      torque_limit_act_o <= 1'b0;
    end else begin
      fwd_move_o    <= run & cmd_fwd_i & fwd_ok;
      rev_move_o    <= run & cmd_rev_i & rev_ok;
      fwd_ot_ff     <= ~fwd_ok;
      rev_ot_ff     <= ~rev_ok;
      ot_stop_o     <= run & ot_hit;
      stop_action_o <= fstop_o ? fs_action : ot_action;
      after_stop_o  <= ot_after;
      // Reverse braking pins the speed reference and caps torque
      speed_ref_zero_o   <= run & ot_hit & (ot_action == otfs_pkg::STOP_RBRK);
      torque_limit_o     <= rb_torq_ff;
      torque_limit_act_o <= run & ot_hit & (ot_action == otfs_pkg::STOP_RBRK);
    end
  end

  assign fwd_ot_o = fwd_ot_ff;
  assign rev_ot_o = rev_ot_ff;

  // Events: overtravel onset, forced-stop entry, enable refused
  assign ev[otfs_pkg::EV_FWD_OT] = ~fwd_ok & ~fwd_ot_ff;
  assign ev[otfs_pkg::EV_REV_OT] = ~rev_ok & ~rev_ot_ff;
  assign ev[otfs_pkg::EV_FSTOP]  = (nxt_state == otfs_pkg::OTFS_FSTOP) &
                                   (state_ff != otfs_pkg::OTFS_FSTOP);
  assign ev[otfs_pkg::EV_HELD]   = cw_enable_i & ~en_ff &
                                   (state_ff == otfs_pkg::OTFS_FSTOP);

  // Sticky status, cleared by reading it; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else if (rd && adr_i == otfs_pkg::ADR_IRQ_STAT) begin
      irq_stat_ff <= ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (wr && adr_i == otfs_pkg::ADR_IRQ_MASK) begin
      irq_mask_ff <= dat_i[otfs_pkg::NEV-1:0];
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // Read mux; unmapped addresses answer with zero
  logic [31:0] rdat;
  always_comb begin
    rdat = 32'h0000_0000;
    case (adr_i)
      otfs_pkg::ADR_CFG_RST:  rdat[5:0]  = cfg_pend_ff;
      otfs_pkg::ADR_ALLOC_A:  rdat[15:0] = alloc_a_ff;
      otfs_pkg::ADR_ALLOC_B:  rdat[3:0]  = alloc_b_ff;
      otfs_pkg::ADR_FS_MODE:  rdat[2:0]  = fs_mode_ff;
      otfs_pkg::ADR_FS_DECEL: rdat[15:0] = fs_decel_ff;
      otfs_pkg::ADR_RB_TORQ:  rdat[8:0]  = rb_torq_ff;
      otfs_pkg::ADR_STATUS:   rdat[11:0] = {term_sync, qs_ok, state_ff,
                                            fwd_ok, rev_ok, fwd_ot_ff, rev_ot_ff};
      otfs_pkg::ADR_IRQ_STAT: rdat[otfs_pkg::NEV-1:0] = irq_stat_ff;
      otfs_pkg::ADR_IRQ_MASK: rdat[otfs_pkg::NEV-1:0] = irq_mask_ff;
      otfs_pkg::ADR_CTRL:     rdat[5:0]  = cfg_act_ff;
      default:                rdat = 32'h0000_0000;
    endcase
  end

  // One wait state: ack and data register together, ack drops next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (rd) begin
        dat_ff <= rdat;
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

endmodule
`default_nettype wire

// ---- otfs_asserts.sv ----
// Port-level checks for overtravel and forced-stop control
`timescale 1ns/1ps
`default_nettype none
module otfs_asserts (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        ack_o,
  input  wire logic        cw_enable_i,
  input  wire logic        fwd_move_o,
  input  wire logic        rev_move_o,
  input  wire logic        fwd_ot_o,
  input  wire logic        rev_ot_o,
  input  wire logic        ot_stop_o,
  input  wire logic        speed_ref_zero_o,
  input  wire logic        torque_limit_act_o,
  input  wire logic [8:0]  torque_limit_o,
  input  wire logic [15:0] decel_time_o,
  input  wire logic        ready_o,
  input  wire logic        servo_on_o,
  input  wire logic        fstop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A fresh request is one not yet answered
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Enable held high through a forced stop for three cycles; fstop_o tracks the state with no lag
  sequence s_held;
    (fstop_o && cw_enable_i) [*3];
  endsequence

  a_bus_answer: assert property (s_req |=> ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property ($rose(ack_o) |=> $fell(ack_o))
    else $error("ack wider than one cycle");
  a_fwd_gate: assert property (fwd_move_o |-> !fwd_ot_o)
    else $error("forward motion while forward prohibited");
  a_rev_gate: assert property (rev_move_o |-> !rev_ot_o)
    else $error("reverse motion while reverse prohibited");
  a_ot_cause: assert property (ot_stop_o |-> (fwd_ot_o || rev_ot_o))
    else $error("overtravel stop with no direction prohibited");
  a_state_onehot: assert property ($onehot({ready_o, servo_on_o, fstop_o}))
    else $error("state outputs not one-hot");
  a_fstop_still: assert property (fstop_o |-> !(fwd_move_o || rev_move_o))
    else $error("motion during forced stop");
  a_fstop_hold: assert property (s_held |=> fstop_o)
    else $error("forced stop left while enable held");
  a_rbrk_pair: assert property (speed_ref_zero_o == torque_limit_act_o)
    else $error("reverse brake outputs disagree");
  a_torque_range: assert property (torque_limit_o <= 9'h15E)
    else $error("torque limit above range");
  // Reset values are checked during reset, so this one has no disable
  a_reset_vals: assert property (disable iff (1'b0) rst_i |=> ready_o &&
    torque_limit_o == 9'h12C && decel_time_o == 16'h03E8)
    else $error("wrong value after reset");
endmodule

bind otfs_top otfs_asserts chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .cw_enable_i,
  .fwd_move_o, .rev_move_o, .fwd_ot_o, .rev_ot_o, .ot_stop_o, .speed_ref_zero_o,
  .torque_limit_act_o, .torque_limit_o, .decel_time_o, .ready_o, .servo_on_o, .fstop_o);
`default_nettype wire

// ---- otfs_far.sv ----
// Far-side model: limit switches, stop source and host enable sequence
`timescale 1ns/1ps
`default_nettype none
module otfs_far (
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  output logic      [4:0] term_o,
  output logic            enable_o
);
  // Normally closed switches idle ON
  initial begin
    term_o   = 5'h1F;
    enable_o = 1'b0;
  end
  // Pins move only just after an edge
  task automatic set_pins(input logic [4:0] lvl);
    @(posedge clk_i);
    term_o <= lvl;
  endtask
  task automatic set_enable(input logic e);
    @(posedge clk_i);
    enable_o <= e;
  endtask
  // Disable, wait for ready, then a fresh enable; bounded wait
  task automatic recover(output logic ok);
    int n;
    n = 0;
    set_enable(1'b0);
    while (ready_i !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    ok = ready_i;
    set_enable(1'b1);
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for overtravel and forced-stop control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, cw_quick_stop_i, cmd_fwd_i, cmd_rev_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [2:0]  qs_option_i;
  logic [31:0] dat_o, q;
  logic [15:0] decel_time_o;
  logic [8:0]  torque_limit_o;
  logic [4:0]  term;
  logic [2:0]  stop_option_o;
  logic [1:0]  stop_action_o, after_stop_o, sa, af;
  logic        ack_o, irq_o, fwd_move_o, rev_move_o, fwd_ot_o, rev_ot_o, ot_stop_o;
  logic        speed_ref_zero_o, torque_limit_act_o, ready_o, servo_on_o, fstop_o;
  logic        use_profile_o, quick_stop_o, en, ok;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 32'h90AC;
  int          act = 0;
  int          m, e;
  int          mdl [int];

  otfs_top dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .irq_o, .term_i(term), .cw_enable_i(en), .cw_quick_stop_i, .qs_option_i,
    .cmd_fwd_i, .cmd_rev_i, .fwd_move_o, .rev_move_o, .fwd_ot_o, .rev_ot_o, .ot_stop_o,
    .stop_action_o, .after_stop_o, .speed_ref_zero_o, .torque_limit_o, .torque_limit_act_o,
    .ready_o, .servo_on_o, .fstop_o, .use_profile_o, .stop_option_o, .decel_time_o,
    .quick_stop_o);
  otfs_far far_u (.clk_i, .ready_i(ready_o), .term_o(term), .enable_o(en));

  always #20 clk_i = ~clk_i;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk(n < 40, 1'b1);
  endtask
  // Write and keep the model; out-of-range values are dropped by the design
  task automatic wr(input logic [7:0] a, input int d);
    wb(1'b1, a, d);
    if (mdl.exists(a) && !(a == otfs_pkg::ADR_FS_MODE && d > 6) &&
        !(a == otfs_pkg::ADR_RB_TORQ && d > 350)) begin
      mdl[a] = d;
    end
    if (a == otfs_pkg::ADR_CTRL) begin
      act = mdl[otfs_pkg::ADR_CFG_RST];
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Sync, decision and output register all pass
  task automatic settle();
    repeat (5) @(posedge clk_i);
  endtask
  task automatic go_run();
    far_u.recover(ok);
    settle();
    chk({ok, servo_on_o}, 2'b11);
  endtask

  initial begin
    {rst_i, cyc_i, stb_i, we_i, cw_quick_stop_i, cmd_fwd_i, cmd_rev_i} = 7'h40;
    {adr_i, sel_i, dat_i, qs_option_i} = {8'h00, 4'hF, 32'h0000_0000, 3'h0};
    mdl[otfs_pkg::ADR_CFG_RST] = 0;
    mdl[otfs_pkg::ADR_ALLOC_A] = 32'h21;
    mdl[otfs_pkg::ADR_ALLOC_B] = 0;
    mdl[otfs_pkg::ADR_FS_MODE] = 0;
    mdl[otfs_pkg::ADR_FS_DECEL] = 1000;
    mdl[otfs_pkg::ADR_RB_TORQ] = 300;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (mdl[a]) rc(a[7:0], mdl[a]);
    rc(8'h3C, 32'h0);
    // Random settings, some out of range
    for (int i = 0; i < 8; i++) begin
      wr(otfs_pkg::ADR_FS_DECEL, $random(seed) & 32'hFFFF);
      wr(otfs_pkg::ADR_RB_TORQ, $random(seed) & 32'h1FF);
      wr(otfs_pkg::ADR_FS_MODE, $random(seed) & 32'h7);
      qs_option_i <= 3'($random(seed));
      repeat (2) @(posedge clk_i);
      chk(decel_time_o, mdl[otfs_pkg::ADR_FS_DECEL]);
      chk(torque_limit_o, mdl[otfs_pkg::ADR_RB_TORQ]);
    end
    foreach (mdl[a]) rc(a[7:0], mdl[a]);
    // The 16-bit deceleration time written through the low lane alone is ignored
    sel_i <= 4'h1;
    wb(1'b1, otfs_pkg::ADR_FS_DECEL, 32'h1234);
    sel_i <= 4'hF;
    rc(otfs_pkg::ADR_FS_DECEL, mdl[otfs_pkg::ADR_FS_DECEL]);
    // Each limit pin in turn, opposite direction still moves
    go_run();
    wb(1'b0, otfs_pkg::ADR_IRQ_STAT, 32'h0);
    wr(otfs_pkg::ADR_IRQ_MASK, 3);
    cmd_fwd_i <= 1'b1;
    cmd_rev_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      far_u.set_pins(i ? 5'h1D : 5'h1E);
      settle();
      chk({fwd_ot_o, rev_ot_o, fwd_move_o, rev_move_o, ot_stop_o, irq_o},
          i ? 6'b011011 : 6'b100111);
      rc(otfs_pkg::ADR_IRQ_STAT, 1 << i);
    end
    settle();
    chk(irq_o, 1'b0);
    // Masked onset stays sticky but silent
    wr(otfs_pkg::ADR_IRQ_MASK, 0);
    far_u.set_pins(5'h1E);
    settle();
    chk(irq_o, 1'b0);
    rc(otfs_pkg::ADR_IRQ_STAT, 32'h1);
    // Limit disables wait for restart
    wr(otfs_pkg::ADR_CFG_RST, 3);
    far_u.set_pins(5'h1C);
    settle();
    chk({fwd_ot_o, rev_ot_o}, 2'b11);
    wr(otfs_pkg::ADR_CTRL, 1);
    rc(otfs_pkg::ADR_CTRL, act);
    go_run();
    chk({fwd_ot_o, rev_ot_o, fwd_move_o, rev_move_o}, 4'b0011);
    // No limit codes allocated turns overtravel off
    wr(otfs_pkg::ADR_CFG_RST, 0);
    wr(otfs_pkg::ADR_CTRL, 1);
    wr(otfs_pkg::ADR_ALLOC_A, 0);
    settle();
    chk({fwd_ot_o, rev_ot_o}, 2'b00);
    wr(otfs_pkg::ADR_ALLOC_A, 32'h21);
    far_u.set_pins(5'h1F);
    // Quick stop only without a stop terminal
    wr(otfs_pkg::ADR_ALLOC_B, 32'hA);
    go_run();
    cw_quick_stop_i <= 1'b1;
    settle();
    chk(quick_stop_o, 1'b0);
    wr(otfs_pkg::ADR_ALLOC_B, 0);
    settle();
    chk(quick_stop_o, 1'b1);
    cw_quick_stop_i <= 1'b0;
    wr(otfs_pkg::ADR_ALLOC_B, 32'hA);
    go_run();
    // Stop pin drops, then returns with enable still high
    far_u.set_pins(5'h0F);
    settle();
    chk({fstop_o, servo_on_o, fwd_move_o, rev_move_o}, 4'b1000);
    far_u.set_pins(5'h1F);
    settle();
    chk(fstop_o, 1'b1);
    wb(1'b0, otfs_pkg::ADR_IRQ_STAT, 32'h0);
    chk(q[otfs_pkg::EV_FSTOP], 1'b1);
    // Enable arriving during a stop keeps it
    far_u.recover(ok);
    far_u.set_enable(1'b0);
    far_u.set_pins(5'h0F);
    settle();
    far_u.set_enable(1'b1);
    far_u.set_enable(1'b0);
    far_u.set_enable(1'b1);
    far_u.set_pins(5'h1F);
    settle();
    chk(fstop_o, 1'b1);
    rc(otfs_pkg::ADR_IRQ_STAT, 32'hC);
    go_run();
    // Stop method latched at restart, then every mode value
    chk({use_profile_o, stop_option_o}, {1'b1, qs_option_i});
    wr(otfs_pkg::ADR_CFG_RST, 4);
    settle();
    chk(use_profile_o, 1'b1);
    wr(otfs_pkg::ADR_CTRL, 1);
    far_u.set_pins(5'h0F);
    settle();
    chk({fstop_o, use_profile_o}, 2'b10);
    for (m = 0; m < 7; m++) begin
      wr(otfs_pkg::ADR_FS_MODE, m);
      e = (m == 3 || m == 4) ? 0 : m;
      sa = e == 0 ? otfs_pkg::STOP_DB : (e == 1 ? otfs_pkg::STOP_COAST : otfs_pkg::STOP_DECEL);
      settle();
      chk({stop_option_o, stop_action_o}, {e[2:0], sa});
    end
    // Overtravel methods; 2 is the vertical-axis choice
    far_u.set_pins(5'h1F);
    for (m = 0; m < 4; m++) begin
      wr(otfs_pkg::ADR_CFG_RST, m << 4);
      wr(otfs_pkg::ADR_CTRL, 1);
      go_run();
      far_u.set_pins(5'h1E);
      sa = m < 2 ? otfs_pkg::STOP_DB : otfs_pkg::STOP_RBRK;
      af = m == 1 ? otfs_pkg::AFT_DB : (m == 2 ? otfs_pkg::AFT_ZCLAMP : otfs_pkg::AFT_COAST);
      settle();
      chk({stop_action_o, after_stop_o, speed_ref_zero_o}, {sa, af, m > 1});
      far_u.set_pins(5'h1F);
    end
    complete_run();
  end
endmodule
`default_nettype wire
